// *** design/dicd_lpf.sv ***
module dicd_lpf
(
	input logic i_clk,
	input logic i_rst_b,
	input logic i_valid,
	input logic [11:0] i_x,
	input logic [3:0] i_shift,
	output logic o_valid,
	output logic [11:0] o_y
);
	dicd_pkg::dicd_lpf_st_t s_reg;
	dicd_pkg::dicd_lpf_st_t s_next;

	always_comb
	begin
		logic signed [20:0] diff;
		logic signed [20:0] step;
		diff = '0;
		step = '0;
		s_next = s_reg;
		s_next.valid = i_valid;
		if (i_valid)
		begin
			diff = $signed({1'b0, i_x, 8'h00}) - $signed({1'b0, s_reg.acc});
			step = diff >>> i_shift;
			s_next.acc = s_reg.acc + step[19:0];
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign o_valid = s_reg.valid;
	assign o_y = s_reg.acc[19:8];
endmodule

// *** design/dicd_pkg.sv ***
// What this block does
// - Scheme 0: a forward, b reverse, else stop.
// - Scheme 0: simultaneous requests, forward wins.
// - Scheme 0: first direction holds; releasing changes.
// - Scheme 1: a runs, b selects reverse.
// - Scheme 2: a runs, b permits starting.
// - Scheme 3: pulse a latches run, b clears.
// - Function 1: closed contact raises external fault.
// - Function 2: open contact raises external fault.
// - Function 3: closed contact permits starting.
// - Function 4: closed contact selects ramp set 2.
// - Function 5: closed reverses, only in scheme 3.
// - Function 6: closed contact selects jog reference.
// - Function 8: closed contact freezes the ramp.
// - Function 9: DC brake while stopped and closed.
// - Voltage range: full span or captured span.
// - Span limits load only by live capture.
// - Inversion maps maximum input to minimum speed.
// - Each analog input has configurable disturbance filter.
// - Current range: 0-20, 4-20 or captured.
// - Reference rescaled; scaling maximum zero disables.
// - Free analog selector: none, voltage, current.
package dicd_pkg;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_FILT = 8'h04;
	localparam logic [7:0] OFS_CAPT = 8'h08;
	localparam logic [7:0] OFS_VSPAN = 8'h0c;
	localparam logic [7:0] OFS_ISPAN = 8'h10;
	localparam logic [7:0] OFS_FLIM = 8'h14;
	localparam logic [7:0] OFS_SCALE = 8'h18;
	localparam logic [7:0] OFS_JOG = 8'h1c;
	localparam logic [7:0] OFS_DCBR = 8'h20;
	localparam logic [7:0] OFS_STAT = 8'h24;
	localparam logic [7:0] OFS_REF = 8'h28;

	localparam int CTRL_SCHEME_LSB = 0;
	localparam int CTRL_CFUNC_LSB = 4;
	localparam int CTRL_VRANGE_BIT = 8;
	localparam int CTRL_IRANGE_LSB = 9;
	localparam int CTRL_VINV_BIT = 11;
	localparam int CTRL_IINV_BIT = 12;
	localparam int CTRL_REFSRC_BIT = 13;
	localparam int CTRL_FREE_LSB = 14;
	localparam int CAPT_VMIN_BIT = 0;
	localparam int CAPT_VMAX_BIT = 1;
	localparam int CAPT_IMIN_BIT = 2;
	localparam int CAPT_IMAX_BIT = 3;

	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [7:0] FILT_RST = 8'h33;
	localparam logic [31:0] FLIM_RST = 32'h01f4_0000;
	localparam logic [31:0] SCALE_RST = 32'h0000_0000;
	localparam logic [15:0] JOG_RST = 16'h0064;
	localparam logic [11:0] DCBR_RST = 12'h200;
	localparam logic [11:0] SPAN_MAX_RST = 12'hfff;

	localparam logic [11:0] AIN_FULL = 12'hfff;
	localparam logic [11:0] AIN_LIVE_ZERO = 12'h333;
	localparam logic [4:0] DIV_LAST = 5'h17;

	typedef enum logic [1:0]
	{
		DICD_DIR_IDLE = 2'b00,
		DICD_DIR_FWD = 2'b01,
		DICD_DIR_REV = 2'b11
	} dicd_dir_t;

	typedef struct packed
	{
		logic run;
		logic reverse;
		logic ext_fault;
		logic fault_reset;
		logic ramp_set2;
		logic ramp_hold;
		logic dc_brake;
		logic jog_sel;
	} dicd_cmd_t;

	typedef struct packed
	{
		logic [19:0] acc;
		logic valid;
	} dicd_lpf_st_t;

	typedef struct packed
	{
		logic busy;
		logic [4:0] cnt;
		logic [12:0] rem;
		logic [23:0] quo;
		logic [11:0] div;
		logic [11:0] norm;
		logic done;
	} dicd_span_st_t;
endpackage

// *** design/dicd_span.sv ***
module dicd_span
(
	input logic i_clk,
	input logic i_rst_b,
	input logic i_start,
	input logic [11:0] i_raw,
	input logic [11:0] i_lo,
	input logic [11:0] i_hi,
	output logic o_done,
	output logic [11:0] o_norm
);
	dicd_pkg::dicd_span_st_t s_reg;
	dicd_pkg::dicd_span_st_t s_next;

	always_comb
	begin
		logic [11:0] diff;
		logic [12:0] t;
		logic [23:0] q;
		diff = i_raw - i_lo;
		t = '0;
		q = '0;
		s_next = s_reg;
		s_next.done = 1'b0;
		// Inputs outside the span clamp at once; others divide serially.
		if (i_start && !s_reg.busy)
		begin
			if (i_raw <= i_lo)
			begin
				s_next.norm = '0;
				s_next.done = 1'b1;
			end
			else if (i_raw >= i_hi)
			begin
				s_next.norm = dicd_pkg::AIN_FULL;
				s_next.done = 1'b1;
			end
			else
			begin
				s_next.busy = 1'b1;
				s_next.cnt = '0;
				s_next.rem = '0;
				s_next.quo = diff * dicd_pkg::AIN_FULL;
				s_next.div = i_hi - i_lo;
			end
		end
		else if (s_reg.busy)
		begin
			t = {s_reg.rem[11:0], s_reg.quo[23]};
			q = {s_reg.quo[22:0], 1'b0};
			if (t >= {1'b0, s_reg.div})
			begin
				t = t - {1'b0, s_reg.div};
				q[0] = 1'b1;
			end
			s_next.rem = t;
			s_next.quo = q;
			s_next.cnt = s_reg.cnt + 5'h01;
			if (s_reg.cnt == dicd_pkg::DIV_LAST)
			begin
				s_next.busy = 1'b0;
				s_next.done = 1'b1;
				s_next.norm = q[11:0];
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign o_done = s_reg.done;
	assign o_norm = s_reg.norm;
endmodule

// *** design/dicd_top.sv ***
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.
module dicd_top
(
	input logic i_clk,
	input logic i_rst_b,
	input logic i_wb_cyc,
	input logic i_wb_stb,
	input logic i_wb_we,
	input logic [7:0] i_wb_adr,
	input logic [3:0] i_wb_sel,
	input logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input logic i_start_input_a,
	input logic i_start_input_b,
	input logic i_programmable_input_c,
	input logic i_motor_stopped,
	input logic i_adc_valid,
	input logic [11:0] i_voltage_reference_input,
	input logic [11:0] i_current_reference_input,
	output dicd_pkg::dicd_cmd_t o_cmd,
	output logic [11:0] o_dc_brake_current,
	output logic [15:0] o_freq_ref,
	output logic [11:0] o_free_analog
);
	typedef struct packed
	{
		logic [31:0] ctrl;
		logic [7:0] filt;
		logic [11:0] vmin;
		logic [11:0] vmax;
		logic [11:0] imin;
		logic [11:0] imax;
		logic [31:0] flim;
		logic [31:0] scale;
		logic [15:0] jog;
		logic [11:0] dcbr;
		dicd_pkg::dicd_dir_t dir;
		logic latch3;
		logic a_q;
		logic b_q;
		logic c_q;
		logic [11:0] vnorm;
		logic [11:0] inorm;
		logic [15:0] ref_out;
		logic [11:0] free;
		dicd_pkg::dicd_cmd_t cmd;
		logic [11:0] brake_cur;
		logic ack;
		logic [31:0] rdata;
	} dicd_state_t;

	localparam dicd_state_t STATE_RST = '{
		ctrl: dicd_pkg::CTRL_RST,
		filt: dicd_pkg::FILT_RST,
		vmin: 12'h000,
		vmax: dicd_pkg::SPAN_MAX_RST,
		imin: 12'h000,
		imax: dicd_pkg::SPAN_MAX_RST,
		flim: dicd_pkg::FLIM_RST,
		scale: dicd_pkg::SCALE_RST,
		jog: dicd_pkg::JOG_RST,
		dcbr: dicd_pkg::DCBR_RST,
		dir: dicd_pkg::DICD_DIR_IDLE,
		latch3: 1'b0,
		a_q: 1'b0,
		b_q: 1'b0,
		c_q: 1'b0,
		vnorm: 12'h000,
		inorm: 12'h000,
		ref_out: 16'h0000,
		free: 12'h000,
		cmd: '0,
		brake_cur: 12'h000,
		ack: 1'b0,
		rdata: 32'h0000_0000
	};

	dicd_state_t s_reg;
	dicd_state_t s_next;

	logic vf_valid;
	logic if_valid;
	logic [11:0] vf_y;
	logic [11:0] if_y;
	logic vs_done;
	logic is_done;
	logic [11:0] vs_norm;
	logic [11:0] is_norm;
	logic [11:0] v_lo;
	logic [11:0] v_hi;
	logic [11:0] i_lo;
	logic [11:0] i_hi;

	// Byte-lane merge of a write into a stored word.
	function automatic logic [31:0] wr_merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int k = 0; k < 4; k++)
		begin
			if (sel[k])
				r[8*k +: 8] = dat[8*k +: 8];
		end
		return r;
	endfunction

	dicd_lpf u_vfilt
	(
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_valid(i_adc_valid),
		.i_x(i_voltage_reference_input),
		.i_shift(s_reg.filt[3:0]),
		.o_valid(vf_valid),
		.o_y(vf_y)
	);

	dicd_lpf u_ifilt
	(
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_valid(i_adc_valid),
		.i_x(i_current_reference_input),
		.i_shift(s_reg.filt[7:4]),
		.o_valid(if_valid),
		.o_y(if_y)
	);

	localparam int CTRL_VRANGE_IDX = dicd_pkg::CTRL_VRANGE_BIT;

	assign v_lo = s_reg.ctrl[CTRL_VRANGE_IDX] ? s_reg.vmin : 12'h000;
	assign v_hi = s_reg.ctrl[CTRL_VRANGE_IDX] ? s_reg.vmax : dicd_pkg::AIN_FULL;

	always_comb
	begin
		case (s_reg.ctrl[dicd_pkg::CTRL_IRANGE_LSB +: 2])
			2'h1:
			begin
				i_lo = dicd_pkg::AIN_LIVE_ZERO;
				i_hi = dicd_pkg::AIN_FULL;
			end
			2'h2:
			begin
				i_lo = s_reg.imin;
				i_hi = s_reg.imax;
			end
			default:
			begin
				i_lo = 12'h000;
				i_hi = dicd_pkg::AIN_FULL;
			end
		endcase
	end

	dicd_span u_vspan
	(
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_start(vf_valid),
		.i_raw(vf_y),
		.i_lo(v_lo),
		.i_hi(v_hi),
		.o_done(vs_done),
		.o_norm(vs_norm)
	);

	dicd_span u_ispan
	(
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_start(if_valid),
		.i_raw(if_y),
		.i_lo(i_lo),
		.i_hi(i_hi),
		.o_done(is_done),
		.o_norm(is_norm)
	);

	always_comb
	begin
		logic req;
		logic a;
		logic b;
		logic c;
		logic [1:0] scheme;
		logic [3:0] cfunc;
		logic ext_fault;
		logic permit;
		logic cmd_run;
		logic cmd_rev;
		logic run_next;
		logic [11:0] norm;
		logic [15:0] lo;
		logic [15:0] hi;
		logic [15:0] span;
		logic [27:0] prod;
		req = i_wb_cyc && i_wb_stb && !s_reg.ack;
		a = i_start_input_a;
		b = i_start_input_b;
		c = i_programmable_input_c;
		scheme = s_reg.ctrl[dicd_pkg::CTRL_SCHEME_LSB +: 2];
		cfunc = s_reg.ctrl[dicd_pkg::CTRL_CFUNC_LSB +: 4];
		ext_fault = 1'b0;
		permit = 1'b1;
		cmd_run = 1'b0;
		cmd_rev = 1'b0;
		run_next = 1'b0;
		norm = '0;
		lo = '0;
		hi = '0;
		span = '0;
		prod = '0;
		s_next = s_reg;
		s_next.a_q = a;
		s_next.b_q = b;
		s_next.c_q = c;

		// Bus slave: one-cycle registered acknowledge, unmapped reads give zero.
		s_next.ack = req;
		s_next.rdata = '0;
		if (req && i_wb_we)
		begin
			if (i_wb_adr == dicd_pkg::OFS_CTRL)
				s_next.ctrl = wr_merge(s_reg.ctrl, i_wb_dat, i_wb_sel);
			else if (i_wb_adr == dicd_pkg::OFS_FILT)
				s_next.filt = 8'(wr_merge({24'h0, s_reg.filt}, i_wb_dat, i_wb_sel));
			else if (i_wb_adr == dicd_pkg::OFS_CAPT && i_wb_sel[0])
			begin
				if (i_wb_dat[dicd_pkg::CAPT_VMIN_BIT])
					s_next.vmin = i_voltage_reference_input;
				if (i_wb_dat[dicd_pkg::CAPT_VMAX_BIT])
					s_next.vmax = i_voltage_reference_input;
				if (i_wb_dat[dicd_pkg::CAPT_IMIN_BIT])
					s_next.imin = i_current_reference_input;
				if (i_wb_dat[dicd_pkg::CAPT_IMAX_BIT])
					s_next.imax = i_current_reference_input;
			end
			else if (i_wb_adr == dicd_pkg::OFS_FLIM)
				s_next.flim = wr_merge(s_reg.flim, i_wb_dat, i_wb_sel);
			else if (i_wb_adr == dicd_pkg::OFS_SCALE)
				s_next.scale = wr_merge(s_reg.scale, i_wb_dat, i_wb_sel);
			else if (i_wb_adr == dicd_pkg::OFS_JOG)
				s_next.jog = 16'(wr_merge({16'h0, s_reg.jog}, i_wb_dat, i_wb_sel));
			else if (i_wb_adr == dicd_pkg::OFS_DCBR)
				s_next.dcbr = 12'(wr_merge({20'h0, s_reg.dcbr}, i_wb_dat, i_wb_sel));
		end
		else if (req)
		begin
			if (i_wb_adr == dicd_pkg::OFS_CTRL)
				s_next.rdata = s_reg.ctrl;
			else if (i_wb_adr == dicd_pkg::OFS_FILT)
				s_next.rdata = {24'h0, s_reg.filt};
			else if (i_wb_adr == dicd_pkg::OFS_VSPAN)
				s_next.rdata = {4'h0, s_reg.vmax, 4'h0, s_reg.vmin};
			else if (i_wb_adr == dicd_pkg::OFS_ISPAN)
				s_next.rdata = {4'h0, s_reg.imax, 4'h0, s_reg.imin};
			else if (i_wb_adr == dicd_pkg::OFS_FLIM)
				s_next.rdata = s_reg.flim;
			else if (i_wb_adr == dicd_pkg::OFS_SCALE)
				s_next.rdata = s_reg.scale;
			else if (i_wb_adr == dicd_pkg::OFS_JOG)
				s_next.rdata = {16'h0, s_reg.jog};
			else if (i_wb_adr == dicd_pkg::OFS_DCBR)
				s_next.rdata = {20'h0, s_reg.dcbr};
			else if (i_wb_adr == dicd_pkg::OFS_STAT)
				s_next.rdata = {21'h0, s_reg.latch3, s_reg.dir, s_reg.cmd};
			else if (i_wb_adr == dicd_pkg::OFS_REF)
				s_next.rdata = {4'h0, s_reg.free, s_reg.ref_out};
		end

		if (cfunc == 4'h1 && c)
			ext_fault = 1'b1;
		if (cfunc == 4'h2 && !c)
			ext_fault = 1'b1;
		if (cfunc == 4'h3)
			permit = c;

		case (scheme)
			2'h0:
			begin
				case (s_reg.dir)
					dicd_pkg::DICD_DIR_FWD:
						s_next.dir = a ? dicd_pkg::DICD_DIR_FWD : (b ? dicd_pkg::DICD_DIR_REV : dicd_pkg::DICD_DIR_IDLE);
					dicd_pkg::DICD_DIR_REV:
						s_next.dir = b ? dicd_pkg::DICD_DIR_REV : (a ? dicd_pkg::DICD_DIR_FWD : dicd_pkg::DICD_DIR_IDLE);
					default:
						s_next.dir = a ? dicd_pkg::DICD_DIR_FWD : (b ? dicd_pkg::DICD_DIR_REV : dicd_pkg::DICD_DIR_IDLE);
				endcase
				cmd_run = s_next.dir != dicd_pkg::DICD_DIR_IDLE;
				cmd_rev = s_next.dir == dicd_pkg::DICD_DIR_REV;
			end
			2'h1:
			begin
				cmd_run = a;
				cmd_rev = b;
			end
			2'h2:
			begin
				cmd_run = a;
				permit = permit && b;
			end
			default:
			begin
				if (b && !s_reg.b_q)
					s_next.latch3 = 1'b0;
				else if (a && !s_reg.a_q)
					s_next.latch3 = 1'b1;
				cmd_run = s_next.latch3;
				cmd_rev = cfunc == 4'h5 && c;
			end
		endcase
		if (scheme != 2'h0)
			s_next.dir = dicd_pkg::DICD_DIR_IDLE;
		if (scheme != 2'h3)
			s_next.latch3 = 1'b0;

		if (ext_fault)
		begin
			s_next.dir = dicd_pkg::DICD_DIR_IDLE;
			s_next.latch3 = 1'b0;
		end
		run_next = cmd_run && !ext_fault && (s_reg.cmd.run || permit);

		s_next.cmd.run = run_next;
		s_next.cmd.reverse = run_next && cmd_rev;
		s_next.cmd.ext_fault = ext_fault;
		s_next.cmd.fault_reset = cfunc == 4'h7 && c && !s_reg.c_q;
		s_next.cmd.ramp_set2 = cfunc == 4'h4 && c;
		s_next.cmd.ramp_hold = cfunc == 4'h8 && c;
		s_next.cmd.jog_sel = cfunc == 4'h6 && c;
		s_next.cmd.dc_brake = cfunc == 4'h9 && c && i_motor_stopped && !run_next;
		s_next.brake_cur = s_next.cmd.dc_brake ? s_reg.dcbr : 12'h000;

		if (vs_done)
			s_next.vnorm = s_reg.ctrl[dicd_pkg::CTRL_VINV_BIT] ? dicd_pkg::AIN_FULL - vs_norm : vs_norm;
		if (is_done)
			s_next.inorm = s_reg.ctrl[dicd_pkg::CTRL_IINV_BIT] ? dicd_pkg::AIN_FULL - is_norm : is_norm;

		norm = s_reg.ctrl[dicd_pkg::CTRL_REFSRC_BIT] ? s_reg.vnorm : s_reg.inorm;
		if (s_reg.scale[31:16] != 16'h0000)
		begin
			lo = s_reg.scale[15:0];
			hi = s_reg.scale[31:16];
		end
		else
		begin
			lo = s_reg.flim[15:0];
			hi = s_reg.flim[31:16];
		end
		span = (hi > lo) ? hi - lo : 16'h0000;
		prod = norm * span;
		s_next.ref_out = lo + prod[27:12];
		if (s_next.cmd.jog_sel)
			s_next.ref_out = s_reg.jog;

		case (s_reg.ctrl[dicd_pkg::CTRL_FREE_LSB +: 2])
			2'h1:
				s_next.free = s_reg.vnorm;
			2'h2:
				s_next.free = s_reg.inorm;
			default:
				s_next.free = 12'h000;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			s_reg <= STATE_RST;
		else
			s_reg <= s_next;
	end

	assign o_wb_ack = s_reg.ack;
	assign o_wb_dat = s_reg.rdata;
	assign o_cmd = s_reg.cmd;
	assign o_dc_brake_current = s_reg.brake_cur;
	assign o_freq_ref = s_reg.ref_out;
	assign o_free_analog = s_reg.free;
endmodule

// *** test/dicd_field.sv ***
module dicd_field
(
	input logic i_clk,
	input logic i_a,
	input logic i_b,
	input logic i_c,
	input logic i_take,
	input logic [11:0] i_v,
	input logic [11:0] i_i,
	output logic o_a,
	output logic o_b,
	output logic o_c,
	output logic o_adc_valid,
	output logic [11:0] o_v,
	output logic [11:0] o_i
);
	timeunit 1ns;
	timeprecision 1ps;

	// Transmitters hold a continuous level, so the sample lines stay valid between conversions.
	always_ff @(posedge i_clk)
	begin
		o_a <= i_a;
		o_b <= i_b;
		o_c <= i_c;
		o_adc_valid <= i_take;
		o_v <= i_v;
		o_i <= i_i;
	end
endmodule

// *** test/dicd_top_assertions.sv ***
module dicd_top_assertions
(
	input logic i_clk,
	input logic i_rst_b,
	input logic i_wb_cyc,
	input logic i_wb_stb,
	input logic i_programmable_input_c,
	input logic i_motor_stopped,
	input logic [31:0] o_wb_dat,
	input logic o_wb_ack,
	input dicd_pkg::dicd_cmd_t o_cmd,
	input logic [11:0] o_dc_brake_current
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);

	AST_ACK_ANSWER: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("request not acknowledged");
	AST_ACK_PULSE: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("acknowledge longer than one cycle");
	AST_RDATA_IDLE: assert property (!o_wb_ack |-> o_wb_dat == 32'h0000_0000)
		else $error("read data outside acknowledge");
	AST_FAULT_STOPS: assert property (o_cmd.ext_fault |-> !o_cmd.run)
		else $error("run with external fault");
	AST_REV_RUNNING: assert property (o_cmd.reverse |-> o_cmd.run)
		else $error("reverse without run");
	AST_BRAKE_STOPPED: assert property (o_cmd.dc_brake |-> !o_cmd.run && $past(i_motor_stopped) && $past(i_programmable_input_c))
		else $error("brake without standstill and contact");
	AST_BRAKE_CURRENT: assert property (!o_cmd.dc_brake |-> o_dc_brake_current == 12'h000)
		else $error("brake current without brake");
	AST_HOLD_CONTACT: assert property (o_cmd.ramp_hold |-> $past(i_programmable_input_c))
		else $error("ramp hold with open contact");
	AST_SET2_CONTACT: assert property (o_cmd.ramp_set2 |-> $past(i_programmable_input_c))
		else $error("ramp set two with open contact");
	AST_JOG_CONTACT: assert property (o_cmd.jog_sel |-> $past(i_programmable_input_c))
		else $error("jog with open contact");
endmodule

bind dicd_top dicd_top_assertions u_dicd_chk
(
	.i_clk(i_clk),
	.i_rst_b(i_rst_b),
	.i_wb_cyc(i_wb_cyc),
	.i_wb_stb(i_wb_stb),
	.i_programmable_input_c(i_programmable_input_c),
	.i_motor_stopped(i_motor_stopped),
	.o_wb_dat(o_wb_dat),
	.o_wb_ack(o_wb_ack),
	.o_cmd(o_cmd),
	.o_dc_brake_current(o_dc_brake_current)
);

// *** test/testbench.sv ***
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [3:0] sel = 4'h0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic ca = 1'b0;
	logic cb = 1'b0;
	logic cc = 1'b0;
	logic ms = 1'b1;
	logic tk = 1'b0;
	logic [11:0] vv = 12'h000;
	logic [11:0] ii = 12'h000;
	logic a_w, b_w, c_w, adcv, ack;
	logic [11:0] v_w, i_w, brk, fra;
	logic [15:0] fref;
	logic [31:0] o_dat;
	dicd_pkg::dicd_cmd_t cmd;
	int error_cnt = 0;
	int samples_checked = 0;
	int seed = 32'he3ae;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	logic [7:0] adr_q[$];
	logic [7:0] on_t[10] = '{8'h00, 8'h20, 8'h00, 8'h00, 8'h08, 8'h00, 8'h01, 8'h00, 8'h04, 8'h02};
	logic [31:0] rst_t[9] = '{32'h0, 32'h33, 32'h0, 32'h0fff_0000, 32'h0fff_0000, 32'h01f4_0000, 32'h0, 32'h64, 32'h200};

	initial
	begin
		forever #4 clk = ~clk;
	end

	dicd_field u_field (.i_clk(clk), .i_a(ca), .i_b(cb), .i_c(cc), .i_take(tk), .i_v(vv), .i_i(ii),
		.o_a(a_w), .o_b(b_w), .o_c(c_w), .o_adc_valid(adcv), .o_v(v_w), .o_i(i_w));

	dicd_top dut (.i_clk(clk), .i_rst_b(rst_b), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
		.i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(o_dat), .o_wb_ack(ack), .i_start_input_a(a_w),
		.i_start_input_b(b_w), .i_programmable_input_c(c_w), .i_motor_stopped(ms), .i_adc_valid(adcv),
		.i_voltage_reference_input(v_w), .i_current_reference_input(i_w), .o_cmd(cmd),
		.o_dc_brake_current(brk), .o_freq_ref(fref), .o_free_analog(fra));

	task automatic conclude;
		if (error_cnt == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	always @(posedge clk)
	begin
		if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
			chk($sformatf("reg_%h", adr_q.pop_front()), o_dat & msk_q.pop_front(), exp_q.pop_front());
	end

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hf;
		@(posedge clk);
		while (ack !== 1'b1 && n < 20)
		begin
			n++;
			@(posedge clk);
		end
		if (n == 20)
			error_cnt++;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		adr_q.push_back(a);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		bus(1'b0, a, 32'h0);
	endtask

	task automatic stat(input logic [7:0] e);
		rd(dicd_pkg::OFS_STAT, {24'h0, e}, 32'h0000_00ff);
	endtask

	task automatic ctrl(input logic [15:0] v);
		bus(1'b1, dicd_pkg::OFS_CTRL, {16'h0, v});
	endtask

	task automatic ct(input logic a, input logic b, input logic c);
		@(posedge clk);
		ca <= a;
		cb <= b;
		cc <= c;
		repeat (3) @(posedge clk);
	endtask

	task automatic smp(input logic [11:0] v, input logic [11:0] i);
		@(posedge clk);
		vv <= v;
		ii <= i;
		tk <= 1'b1;
		@(posedge clk);
		tk <= 1'b0;
		repeat (32) @(posedge clk);
	endtask

	function automatic int nrm(int x, int lo, int hi);
		return (x <= lo) ? 0 : (x >= hi) ? 4095 : (x - lo) * 4095 / (hi - lo);
	endfunction

	initial
	begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		conclude();
	end

	initial
	begin
		int v, i, f, fr, vn;
		logic inv;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		for (int k = 0; k < 9; k++)
			rd(8'(4 * k), rst_t[k], 32'hffff_ffff);
		rd(8'h3c, 32'h0, 32'hffff_ffff);
		ct(1, 0, 0);
		stat(8'h80);
		ct(1, 1, 0);
		stat(8'h80);
		ct(0, 1, 0);
		stat(8'hc0);
		ct(0, 0, 0);
		stat(8'h00);
		ct(1, 1, 0);
		stat(8'h80);
		ctrl(16'h0001);
		stat(8'hc0);
		ct(1, 0, 0);
		stat(8'h80);
		ct(0, 1, 0);
		stat(8'h00);
		ctrl(16'h0002);
		ct(1, 0, 0);
		stat(8'h00);
		ct(1, 1, 0);
		stat(8'h80);
		ctrl(16'h0053);
		ct(0, 0, 0);
		ct(1, 0, 0);
		ct(0, 0, 0);
		stat(8'h80);
		ct(0, 0, 1);
		stat(8'hc0);
		ct(0, 1, 1);
		stat(8'h00);
		ctrl(16'h0050);
		ct(1, 0, 1);
		stat(8'h80);
		ctrl(16'h0030);
		ct(0, 0, 0);
		ct(1, 0, 0);
		stat(8'h00);
		ct(1, 0, 1);
		stat(8'h80);
		ctrl(16'h0010);
		stat(8'h20);
		ct(0, 0, 0);
		for (int k = 0; k < 10; k++)
		begin
			ctrl(16'(k * 16));
			ct(0, 0, 1);
			stat(on_t[k]);
			chk("brake_current", 32'(brk), (k == 9) ? 32'(dicd_pkg::DCBR_RST) : 32'h0);
			ct(0, 0, 0);
			stat((k == 2) ? 8'h20 : 8'h00);
		end
		ms <= 1'b0;
		ct(0, 0, 1);
		stat(8'h00);
		ms <= 1'b1;
		bus(1'b1, dicd_pkg::OFS_FILT, 32'h0);
		for (int k = 0; k < 6; k++)
		begin
			f = k % 3;
			inv = (f != 1) && k[0];
			ctrl({2'(f), 1'b1, 1'b0, inv, 2'(f), 1'b0, 8'h00});
			v = $random(seed) & 32'hfff;
			i = $random(seed) & 32'hfff;
			smp(12'(v), 12'(i));
			vn = inv ? 4095 - v : v;
			fr = (f == 0) ? 0 : (f == 1) ? vn : nrm(i, (f == 1) ? 'h333 : 0, 4095);
			fr = (f == 2 && k == 5) ? nrm(i, 0, 4095) : fr;
			rd(dicd_pkg::OFS_REF, {4'h0, 12'(fr), 16'(vn * 500 / 4096)}, 32'hffff_ffff);
			chk("freq_ref", 32'(fref), 32'(vn * 500 / 4096));
			chk("free_analog", 32'(fra), 32'(fr));
		end
		ctrl(16'ha200);
		smp(12'h800, 12'h999);
		rd(dicd_pkg::OFS_REF, {4'h0, 12'(nrm('h999, 'h333, 4095)), 16'd250}, 32'hffff_ffff);
		bus(1'b1, dicd_pkg::OFS_SCALE, {16'd200, 16'd100});
		smp(12'h800, 12'h0);
		rd(dicd_pkg::OFS_REF, 32'd150, 32'h0000_ffff);
		bus(1'b1, dicd_pkg::OFS_SCALE, {16'd0, 16'd100});
		smp(12'h800, 12'h0);
		rd(dicd_pkg::OFS_REF, 32'd250, 32'h0000_ffff);
		smp(12'h100, 12'h0);
		bus(1'b1, dicd_pkg::OFS_CAPT, 32'h1);
		smp(12'h900, 12'h0);
		bus(1'b1, dicd_pkg::OFS_CAPT, 32'h2);
		rd(dicd_pkg::OFS_VSPAN, 32'h0900_0100, 32'hffff_ffff);
		ctrl(16'h2100);
		smp(12'h500, 12'h0);
		rd(dicd_pkg::OFS_REF, 32'(nrm('h500, 'h100, 'h900) * 500 / 4096), 32'h0000_ffff);
		ctrl(16'h2060);
		ct(0, 0, 1);
		smp(12'h500, 12'h0);
		rd(dicd_pkg::OFS_REF, 32'h64, 32'h0000_ffff);
		ctrl(16'h2000);
		bus(1'b1, dicd_pkg::OFS_FILT, 32'h1);
		smp(12'hd00, 12'h0);
		rd(dicd_pkg::OFS_REF, 32'((('h500 + 'hd00) / 2) * 500 / 4096), 32'h0000_ffff);
		conclude();
	end
endmodule
